// file: rtl/owd_session_ctrl.sv
// one-wire debug port session control and direct load/store handling
//
// Summary of operation
// R1: programmer should reset the system before a high-voltage entry.
// R2: after pin release, no sync start within the time-out disables the port.
// R3: a sync too long or too short for baud recovery disables the port.
// R4: self-disable drops power requests; only a new enable restarts it.
// R5: programmer ends sessions by setting the session disable bit.
// R6: session disable issues a system reset and disables the port.
// R7: that reset restarts the cpu, drops the clock request, clears settings.
// R8: parity, contention, frame and access time-out errors store a code.
// R9: any error enters an error state that ignores all but a break; the code also leaves it on session disable or a bad sync.
// R10: debugger recovers with break, sync, then reading the error code.
// R11: idle guard bits precede the first response byte after receiving.
// R12: idle before a response is at least the guard, at most the time-out.
// R13: device should use two or more guard bits, debugger one.
// R14: each instruction is one byte preceded by a sync character.
// R15: instructions reach the port's own space and the system space; the code decodes only load and store, to the system bus.
// R16: direct load takes address bytes per size field, returns data bytes.
// R17: direct load data is sent only after the guard time.
// R18: repeated loads resend the address; no automatic increment.
// R19: the decoded access is handed to the bus side; delay is tolerated.
// R20: direct store sends address then data, each up to 32 bits.
// R21: store acknowledges after the address and again after the data.
// R22: the sync character is the fixed alternating value 0x55.
`timescale 1ns/1ps
`default_nettype none
`include "owd_regs.svh"
module owd_session_ctrl #(
  parameter int unsigned STARTUP_TO_CYC = `OWD_STARTUP_TO_CYC,
  parameter int unsigned ACCESS_TO_CYC  = `OWD_ACCESS_TO_CYC
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          enable_i,
  input  wire logic          sync_start_i,
  input  wire logic          sync_done_i,
  input  wire logic [15:0]   sync_len_i,
  input  wire logic          rx_valid_i,
  input  wire logic [7:0]    rx_data_i,
  input  wire logic          break_i,
  input  wire logic          err_parity_i,
  input  wire logic          err_frame_i,
  input  wire logic          err_contention_i,
  input  wire logic          session_disable_i,
  input  wire logic [2:0]    guard_time_count_i,
  output logic               bus_req_o,
  output owd_pkg::owd_bus_cmd_t bus_cmd_o,
  input  wire logic          bus_ack_i,
  input  wire logic [31:0]   bus_rdata_i,
  output logic               tx_valid_o,
  output logic [7:0]         tx_data_o,
  input  wire logic          tx_ready_i,
  output logic               enabled_o,
  output logic               clk_req_o,
  output logic               sys_reset_o,
  output logic               error_state_o,
  output logic [2:0]         error_signature_o,
  output logic [11:0]        baud_o
);
  import owd_pkg::*;

  localparam logic [16:0] ACC_LAST = 17'(ACCESS_TO_CYC - 1);

  function automatic logic [31:0] put_byte(logic [31:0] w, logic [1:0] idx, logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[{idx, 3'b000} +: 8] = b;
    return r;
  endfunction

  owd_state_t  state_q;
  owd_state_t  state_d;
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  logic [1:0]  asz_q;
  logic [1:0]  asz_d;
  logic [1:0]  dsz_q;
  logic [1:0]  dsz_d;
  logic        store_q;
  logic        store_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic [31:0] data_q;
  logic [31:0] data_d;
  logic        bus_req_q;
  logic        bus_req_d;
  logic [16:0] acc_q;
  logic [16:0] acc_d;
  owd_err_t    err_q;
  owd_err_t    err_d;
  logic [11:0] baud_q;
  logic [11:0] baud_d;
  logic        sys_rst_q;
  logic        sys_rst_d;
  logic [14:0] guard_q;
  logic [14:0] guard_d;

  logic        push_valid;
  logic        push_ready;
  logic [7:0]  push_data;
  logic        flush;
  logic        fifo_valid;
  logic        to_pulse;
  logic        sync_ok;
  logic        sync_bad;
  logic        active;
  logic        phy_err;
  logic        acc_to;
  logic [2:0]  opcode;

  owd_sync_mon #(
    .TO_CYC (STARTUP_TO_CYC)
  ) u_sync (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .arm_i        (state_q == OWD_ST_STARTUP),
    .sync_start_i (sync_start_i),
    .sync_done_i  (sync_done_i),
    .sync_len_i   (sync_len_i),
    .timeout_o    (to_pulse),
    .sync_ok_o    (sync_ok),
    .sync_bad_o   (sync_bad)
  );

  owd_fifo #(
    .WIDTH (8),
    .DEPTH (`OWD_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (flush),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (tx_ready_i && guard_q == '0),
    .out_data_o  (tx_data_o)
  );

  assign opcode  = rx_data_i[`OWD_OP_POS +: 3];
  assign active  = state_q != OWD_ST_OFF && state_q != OWD_ST_STARTUP && state_q != OWD_ST_ERROR;
  assign phy_err = err_parity_i || err_frame_i || err_contention_i;
  // see R12: a stuck bus access ends in an error, bounding the idle time
  assign acc_to  = (state_q == OWD_ST_READ || state_q == OWD_ST_WRITE) && acc_q == ACC_LAST;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    asz_d      = asz_q;
    dsz_d      = dsz_q;
    store_d    = store_q;
    addr_d     = addr_q;
    data_d     = data_q;
    bus_req_d  = bus_req_q;
    acc_d      = acc_q;
    err_d      = err_q;
    baud_d     = baud_q;
    sys_rst_d  = 1'b0;
    push_valid = 1'b0;
    push_data  = (state_q == OWD_ST_RESP) ? data_q[{cnt_q, 3'b000} +: 8] : `OWD_ACK_BYTE;
    flush      = 1'b0;
    if (state_q != OWD_ST_OFF && session_disable_i) begin
      // see R6 see R7: reset pulse, clock request dropped, settings cleared
      state_d   = OWD_ST_OFF;
      sys_rst_d = 1'b1;
      baud_d    = '0;
      err_d     = OWD_ERR_NONE;
      bus_req_d = 1'b0;
      flush     = 1'b1;
    end else if (state_q != OWD_ST_OFF && sync_bad) begin
      state_d   = OWD_ST_OFF; // see R3 see R4
      bus_req_d = 1'b0;
      flush     = 1'b1;
    end else if (state_q != OWD_ST_OFF && state_q != OWD_ST_STARTUP && break_i) begin
      state_d   = OWD_ST_SYNC; // see R9: only a break takes the error state back to sync
      bus_req_d = 1'b0;
      flush     = 1'b1;
    end else if (active && (phy_err || acc_to)) begin
      // see R8 see R9
      state_d   = OWD_ST_ERROR;
      bus_req_d = 1'b0;
      flush     = 1'b1;
      if (err_contention_i) begin
        err_d = OWD_ERR_CONTENTION;
      end else if (err_frame_i) begin
        err_d = OWD_ERR_FRAME;
      end else if (err_parity_i) begin
        err_d = OWD_ERR_PARITY;
      end else begin
        err_d = OWD_ERR_ACCESS_TO;
      end
    end else begin
      unique case (state_q)
        OWD_ST_OFF: begin
          if (enable_i) begin
            state_d = OWD_ST_STARTUP;
          end
        end
        OWD_ST_STARTUP, OWD_ST_SYNC: begin
          if (state_q == OWD_ST_STARTUP && to_pulse) begin
            state_d = OWD_ST_OFF; // see R2 see R4
          end else if (sync_ok) begin
            baud_d  = sync_len_i[`OWD_BAUD_LSB +: 12];
            state_d = OWD_ST_INSTR;
          end
        end
        OWD_ST_INSTR: begin
          if (rx_valid_i) begin
            cnt_d = 2'h0;
            asz_d = rx_data_i[`OWD_ASIZE_POS +: 2];
            dsz_d = rx_data_i[`OWD_DSIZE_POS +: 2];
            // see R14 see R15: unsupported codes wait for the next sync
            if (opcode == `OWD_OP_LOAD || opcode == `OWD_OP_STORE) begin
              store_d = opcode == `OWD_OP_STORE;
              addr_d  = '0;
              state_d = OWD_ST_ADDR;
            end else begin
              state_d = OWD_ST_SYNC;
            end
          end
        end
        OWD_ST_ADDR: begin
          if (rx_valid_i) begin
            addr_d = put_byte(addr_q, cnt_q, rx_data_i); // see R16 see R20
            if (cnt_q == asz_q) begin
              cnt_d = 2'h0;
              if (store_q) begin
                state_d = OWD_ST_ACK1;
              end else begin
                bus_req_d = 1'b1; // see R19
                acc_d     = '0;
                state_d   = OWD_ST_READ;
              end
            end else begin
              cnt_d = cnt_q + 2'h1;
            end
          end
        end
        OWD_ST_READ, OWD_ST_WRITE: begin
          acc_d = acc_q + 17'h1;
          if (bus_ack_i) begin
            bus_req_d = 1'b0;
            cnt_d     = 2'h0;
            data_d    = store_q ? data_q : bus_rdata_i;
            state_d   = store_q ? OWD_ST_ACK2 : OWD_ST_RESP;
          end
        end
        OWD_ST_RESP: begin
          push_valid = 1'b1; // see R16: data bytes least significant first
          if (push_ready) begin
            if (cnt_q == dsz_q) begin
              state_d = OWD_ST_SYNC; // see R18: next load carries its own address
            end else begin
              cnt_d = cnt_q + 2'h1;
            end
          end
        end
        OWD_ST_ACK1: begin
          push_valid = 1'b1; // see R21
          if (push_ready) begin
            data_d  = '0;
            state_d = OWD_ST_DATA;
          end
        end
        OWD_ST_DATA: begin
          if (rx_valid_i) begin
            data_d = put_byte(data_q, cnt_q, rx_data_i); // see R20
            if (cnt_q == dsz_q) begin
              bus_req_d = 1'b1;
              acc_d     = '0;
              state_d   = OWD_ST_WRITE;
            end else begin
              cnt_d = cnt_q + 2'h1;
            end
          end
        end
        OWD_ST_ACK2: begin
          push_valid = 1'b1; // see R21
          if (push_ready) begin
            state_d = OWD_ST_SYNC;
          end
        end
        OWD_ST_ERROR: begin
          state_d = OWD_ST_ERROR;
        end
        default: begin
          state_d = OWD_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= OWD_ST_OFF;
      cnt_q     <= '0;
      asz_q     <= '0;
      dsz_q     <= '0;
      store_q   <= 1'b0;
      addr_q    <= '0;
      data_q    <= '0;
      bus_req_q <= 1'b0;
      acc_q     <= '0;
      err_q     <= OWD_ERR_NONE;
      baud_q    <= '0;
      sys_rst_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      asz_q     <= asz_d;
      dsz_q     <= dsz_d;
      store_q   <= store_d;
      addr_q    <= addr_d;
      data_q    <= data_d;
      bus_req_q <= bus_req_d;
      acc_q     <= acc_d;
      err_q     <= err_d;
      baud_q    <= baud_d;
      sys_rst_q <= sys_rst_d;
    end
  end

  // guard reloads on every received byte, so it always counts from the last one
  always_comb begin
    guard_d = guard_q;
    if (rx_valid_i) begin
      guard_d = {3'b000, baud_q} * {12'h000, guard_time_count_i}; // see R11 see R13 see R17
    end else if (guard_q != '0) begin
      guard_d = guard_q - 15'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      guard_q <= '0;
    end else begin
      guard_q <= guard_d;
    end
  end

  assign tx_valid_o        = fifo_valid && guard_q == '0; // see R11
  assign bus_req_o         = bus_req_q;
  assign bus_cmd_o         = '{we: store_q, size: dsz_q, addr: addr_q, wdata: data_q};
  assign clk_req_o         = state_q != OWD_ST_OFF; // see R4
  assign enabled_o         = state_q != OWD_ST_OFF && state_q != OWD_ST_STARTUP;
  assign error_state_o     = state_q == OWD_ST_ERROR;
  assign error_signature_o = err_q;
  assign baud_o            = baud_q;
  assign sys_reset_o       = sys_rst_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_store_addr_done;
    state_q == OWD_ST_ADDR && rx_valid_i && cnt_q == asz_q && store_q
      && !session_disable_i && !sync_bad && !break_i && !phy_err;
  endsequence

  sequence s_load_addr_done;
    state_q == OWD_ST_ADDR && rx_valid_i && cnt_q == asz_q && !store_q
      && !session_disable_i && !sync_bad && !break_i && !phy_err;
  endsequence

  startup_timeout_a: assert property ( // see R2
    state_q == OWD_ST_STARTUP && to_pulse && !session_disable_i && !sync_bad
      |=> state_q == OWD_ST_OFF && !clk_req_o)
    else $error("start-up time-out did not disable the port");
  bad_sync_off_a: assert property ( // see R3
    state_q != OWD_ST_OFF && sync_bad |=> state_q == OWD_ST_OFF)
    else $error("bad sync did not disable the port");
  off_quiet_a: assert property ( // see R4
    state_q == OWD_ST_OFF && !enable_i |=> !clk_req_o && !bus_req_o && !enabled_o)
    else $error("disabled port still requests clock or bus");
  disable_reset_a: assert property ( // see R6
    state_q != OWD_ST_OFF && session_disable_i
      |=> sys_reset_o && state_q == OWD_ST_OFF ##1 !sys_reset_o)
    else $error("session disable did not give one reset pulse");
  reset_clears_a: assert property ( // see R7
    sys_reset_o |-> baud_o == 12'h000 && error_signature_o == OWD_ERR_NONE && !clk_req_o)
    else $error("reset left settings or clock request");
  parity_code_a: assert property ( // see R8
    active && err_parity_i && !err_frame_i && !err_contention_i
      && !session_disable_i && !sync_bad && !break_i
      |=> error_state_o && error_signature_o == OWD_ERR_PARITY)
    else $error("parity error not recorded");
  error_holds_a: assert property ( // see R9
    error_state_o && !break_i && !session_disable_i && !sync_bad
      |=> error_state_o && !bus_req_o)
    else $error("error state left without a break");
  guard_blocks_tx_a: assert property ( // see R11
    rx_valid_i && guard_time_count_i != 3'h0 && baud_o != 12'h000 |=> !tx_valid_o)
    else $error("response sent inside the guard time");
  load_request_a: assert property ( // see R16
    s_load_addr_done |=> bus_req_o && !bus_cmd_o.we
      && bus_cmd_o.addr == put_byte($past(addr_q), $past(cnt_q), $past(rx_data_i)))
    else $error("direct load did not request the received address");
  store_ack_a: assert property ( // see R21
    s_store_addr_done |=> state_q == OWD_ST_ACK1 && !bus_req_o)
    else $error("store address not followed by an acknowledge");

endmodule
`default_nettype wire

// file: rtl/owd_regs.svh
// constants for the one-wire debug session controller
`ifndef OWD_REGS_SVH
`define OWD_REGS_SVH

`define OWD_STARTUP_TO_CYC 65536
`define OWD_ACCESS_TO_CYC  65536
`define OWD_OP_POS         5
`define OWD_ASIZE_POS      2
`define OWD_DSIZE_POS      0
`define OWD_OP_LOAD        3'h0
`define OWD_OP_STORE       3'h2
`define OWD_ACK_BYTE       8'h40
`define OWD_SYNC_MAX_LEN   16'h7FFF
`define OWD_SYNC_MIN_LEN   16'h0040
`define OWD_BAUD_LSB       3
`define OWD_FIFO_DEPTH     16

`endif

// file: rtl/owd_pkg.sv
// types shared by the one-wire debug session controller
package owd_pkg;

  typedef enum logic [3:0] {
    OWD_ST_OFF     = 4'h0,
    OWD_ST_STARTUP = 4'h1,
    OWD_ST_SYNC    = 4'h2,
    OWD_ST_INSTR   = 4'h3,
    OWD_ST_ADDR    = 4'h4,
    OWD_ST_READ    = 4'h5,
    OWD_ST_RESP    = 4'h6,
    OWD_ST_ACK1    = 4'h7,
    OWD_ST_DATA    = 4'h8,
    OWD_ST_WRITE   = 4'h9,
    OWD_ST_ACK2    = 4'hA,
    OWD_ST_ERROR   = 4'hB
  } owd_state_t;

  typedef enum logic [2:0] {
    OWD_ERR_NONE       = 3'h0,
    OWD_ERR_PARITY     = 3'h1,
    OWD_ERR_FRAME      = 3'h2,
    OWD_ERR_ACCESS_TO  = 3'h3,
    OWD_ERR_CONTENTION = 3'h5
  } owd_err_t;

  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } owd_bus_cmd_t;

endpackage

// file: rtl/owd_fifo.sv
// response byte fifo between the session controller and the transmitter
`timescale 1ns/1ps
`default_nettype none
module owd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  import owd_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;

  assign in_ready_o  = (wr_q - rd_q) != FULL_CNT;
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    if (flush_i) begin
      wr_d = '0;
      rd_d = '0;
    end else begin
      if (in_valid_i && in_ready_o) begin
        mem_d[wr_q[AW-1:0]] = in_data_i;
        wr_d = wr_q + 1'b1;
      end
      if (out_valid_o && out_ready_i) begin
        rd_d = rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // payload needs no reset; pointers guard it
  always_ff @(posedge clk_sys_i) begin
    mem_q <= mem_d;
  end

  fill_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !in_ready_o && !out_ready_i && !flush_i |=> !in_ready_o)
    else $error("fifo lost its full state without a pop");

endmodule
`default_nettype wire

// file: rtl/owd_sync_mon.sv
// start-up time-out counter and sync character length check
`timescale 1ns/1ps
`default_nettype none
`include "owd_regs.svh"
module owd_sync_mon #(
  parameter int unsigned TO_CYC = `OWD_STARTUP_TO_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        arm_i,
  input  wire logic        sync_start_i,
  input  wire logic        sync_done_i,
  input  wire logic [15:0] sync_len_i,
  output logic             timeout_o,
  output logic             sync_ok_o,
  output logic             sync_bad_o
);
  import owd_pkg::*;

  localparam logic [16:0] TO_LAST = 17'(TO_CYC - 1);

  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic        seen_q;
  logic        seen_d;
  logic        len_ok;

  // see R3: too long overflows the baud register, too short cannot be sampled
  assign len_ok     = sync_len_i <= `OWD_SYNC_MAX_LEN && sync_len_i >= `OWD_SYNC_MIN_LEN;
  assign sync_ok_o  = sync_done_i && len_ok;
  assign sync_bad_o = sync_done_i && !len_ok;
  assign timeout_o  = arm_i && !seen_q && cnt_q == TO_LAST; // see R2

  always_comb begin
    cnt_d  = cnt_q;
    seen_d = seen_q;
    if (!arm_i) begin
      cnt_d  = '0;
      seen_d = 1'b0;
    end else if (sync_start_i) begin
      seen_d = 1'b1;
    end else if (!seen_q && cnt_q != TO_LAST) begin
      cnt_d = cnt_q + 17'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
    end
  end

  start_stops_to_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R2
    arm_i && sync_start_i |=> !timeout_o)
    else $error("time-out fired after the sync start bit");

endmodule
`default_nettype wire

// file: sim/owd_bus_model.sv
// system bus responder standing behind the session controller
`timescale 1ns/1ps
`default_nettype none
module owd_bus_model (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  slow_i,
  input  wire logic                  hang_i,
  input  wire logic                  bus_req_i,
  input  wire owd_pkg::owd_bus_cmd_t bus_cmd_i,
  output logic                       bus_ack_o,
  output logic [31:0]                bus_rdata_o,
  output owd_pkg::owd_bus_cmd_t      last_cmd_o
);
  import owd_pkg::*;
  logic [3:0] wait_q;
  // read data follows the address so the bench can predict it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_ack_o <= 1'b0;
      wait_q <= 4'h0;
      bus_rdata_o <= 32'h0000_0000;
      last_cmd_o <= '0;
    // hang withholds the acknowledge so the access time-out can be provoked
    end else if (!bus_ack_o && bus_req_i && !hang_i && wait_q == (slow_i ? 4'h6 : 4'h0)) begin
      bus_ack_o <= 1'b1;
      wait_q <= 4'h0;
      bus_rdata_o <= bus_cmd_i.addr ^ 32'hA5A5_5A5A;
      last_cmd_o <= bus_cmd_i;
    end else begin
      bus_ack_o <= 1'b0;
      wait_q <= (bus_req_i && !bus_ack_o) ? wait_q + 4'h1 : 4'h0;
      // outside the acknowledge cycle the read data inverts every cycle
      bus_rdata_o <= ~bus_rdata_o;
    end
  end
endmodule
`default_nettype wire

// file: sim/owd_session_ctrl_test.sv
// self-checking bench for the session controller
`timescale 1ns/1ps
`default_nettype none
module owd_session_ctrl_test;
  import owd_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, enable_i = 0, sync_start_i = 0, sync_done_i = 0;
  logic rx_valid_i = 0, break_i = 0, err_parity_i = 0, err_frame_i = 0;
  logic err_contention_i = 0, session_disable_i = 0, slow = 0, hang = 0;
  logic [15:0] sync_len_i = 16'h0000;
  logic [7:0] rx_data_i = 8'h00, tx_data_o;
  logic [2:0] guard_time_count_i = 3'h2, error_signature_o;
  logic bus_req_o, bus_ack, tx_valid_o, enabled_o, clk_req_o, sys_reset_o, error_state_o;
  logic [31:0] bus_rdata, adr, dat;
  logic [11:0] baud_o;
  owd_bus_cmd_t bus_cmd_o, last_cmd;
  logic [7:0] exp_q[$];
  int n_fail = 0, checks_done = 0, n;
  owd_session_ctrl #(.STARTUP_TO_CYC(64), .ACCESS_TO_CYC(64)) u_dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .enable_i(enable_i), .sync_start_i(sync_start_i),
    .sync_done_i(sync_done_i), .sync_len_i(sync_len_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .break_i(break_i), .err_parity_i(err_parity_i),
    .err_frame_i(err_frame_i), .err_contention_i(err_contention_i),
    .session_disable_i(session_disable_i), .guard_time_count_i(guard_time_count_i),
    .bus_req_o(bus_req_o), .bus_cmd_o(bus_cmd_o), .bus_ack_i(bus_ack),
    .bus_rdata_i(bus_rdata), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(1'b1), .enabled_o(enabled_o), .clk_req_o(clk_req_o),
    .sys_reset_o(sys_reset_o), .error_state_o(error_state_o),
    .error_signature_o(error_signature_o), .baud_o(baud_o));
  owd_bus_model u_bus (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow), .hang_i(hang),
    .bus_req_i(bus_req_o), .bus_cmd_i(bus_cmd_o), .bus_ack_o(bus_ack),
    .bus_rdata_o(bus_rdata), .last_cmd_o(last_cmd));
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge clk_sys_i);
  endtask
  task automatic send(input logic [7:0] b);
    rx_valid_i = 1;
    rx_data_i = b;
    tick(1);
    rx_valid_i = 0;
    // quiet cycle, so valid never falls and rises in one step
    tick(1);
  endtask
  task automatic sync(input logic [15:0] len);
    sync_start_i = 1;
    tick(1);
    sync_start_i = 0;
    sync_done_i = 1;
    sync_len_i = len;
    tick(1);
    sync_done_i = 0;
    tick(1);
  endtask
  // bounded wait for the scoreboard to drain, returns cycles spent
  task automatic drain();
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      tick(1);
      n++;
    end
    if (exp_q.size() != 0) tally_and_finish();
  endtask
  task automatic tally_and_finish();
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // read on the falling edge, clear of the rising edge that moves the fifo
  always @(negedge clk_sys_i) begin
    if (tx_valid_o === 1'b1) begin
      if (exp_q.size() == 0) chk(tx_data_o, 32'hFFFF_FFFF);
      else chk(tx_data_o, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(2917));
    tick(10); // whole system held in reset first
    chk(clk_req_o, 0);
    rst_n_i = 1;
    enable_i = 1;
    tick(1);
    enable_i = 0;
    n = 0;
    while (clk_req_o !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    chk(n, 64);
    if (n >= 200) tally_and_finish();
    enable_i = 1;
    tick(1);
    enable_i = 0;
    sync(16'h0100);
    chk(baud_o, 12'h020);
    for (int k = 0; k < 2; k++) begin
      adr = $urandom;
      slow = k[0];
      exp_q.push_back(adr[7:0] ^ 8'h5A);
      exp_q.push_back(adr[15:8] ^ 8'h5A);
      // two address bytes, two data bytes back
      send(8'h05);
      send(adr[7:0]);
      send(adr[15:8]);
      drain();
      chk(n >= 64, 1);
      chk(last_cmd.addr, {16'h0000, adr[15:0]});
      chk(last_cmd.we, 0);
      chk(last_cmd.size, 2'h1);
      sync(16'h0100);
    end
    adr = $urandom;
    dat = $urandom;
    exp_q.push_back(8'h40);
    send(8'h40);
    send(adr[7:0]);
    drain();
    chk(n >= 60, 1);
    exp_q.push_back(8'h40);
    send(dat[7:0]);
    drain();
    chk(last_cmd.addr, {24'h00_0000, adr[7:0]});
    chk({last_cmd.we, last_cmd.size}, 3'h4);
    chk(last_cmd.wdata, {24'h0, dat[7:0]});
    for (int k = 0; k < 3; k++) begin
      sync(16'h0100);
      err_parity_i = (k == 0);
      err_frame_i = (k == 1);
      err_contention_i = (k == 2);
      tick(1);
      {err_parity_i, err_frame_i, err_contention_i} = 3'b000;
      tick(1);
      chk(error_state_o, 1);
      chk(error_signature_o, (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : 3'h5);
      send(8'h00);
      tick(3);
      chk(bus_req_o, 0);
      break_i = 1;
      tick(1);
      break_i = 0;
      tick(1);
      chk(error_state_o, 0);
    end
    // a bus that never answers must end in the access time-out error
    hang = 1;
    sync(16'h0100);
    send(8'h00);
    send(adr[7:0]);
    tick(70);
    chk(error_state_o, 1);
    chk(error_signature_o, 3'h3);
    chk(bus_req_o, 0);
    hang = 0;
    break_i = 1;
    tick(1);
    break_i = 0;
    tick(1);
    sync(16'h0100);
    chk(error_signature_o, 3'h3);
    sync(16'h0010);
    chk(enabled_o, 0);
    chk(clk_req_o, 0);
    enable_i = 1;
    tick(1);
    enable_i = 0;
    sync(16'h0100);
    session_disable_i = 1;
    tick(1);
    session_disable_i = 0;
    chk(sys_reset_o, 1);
    tick(1);
    chk({sys_reset_o, clk_req_o, baud_o}, 0);
    chk(error_signature_o, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
